// ### dv/acs_host_model.sv
// Host model: master clock, convert start, calibration request and serial frames
`timescale 1ns/1ps
module acs_host_model (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Device serial pins
	input wire logic dout_i,
	input wire logic dout_oe_n_i,
	input wire logic din_i,
	input wire logic din_oe_n_i,
	// Host pins
	output acs_pkg::acs_pins_t pins_o
);
	logic [2:0] mdiv = 3'h0;
	logic mclk = 1'b0;
	logic cnv_n = 1'b1;
	logic cal = 1'b0;
	logic fsync = 1'b1;
	logic sclk = 1'b0;
	logic hdin = 1'b0;
	logic hdrv = 1'b0;
	logic last = 1'b0;
	int cnv_left = 0;
	int cal_left = 0;

	// Free-running 4 MHz master clock, held at its idle level through reset
	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mdiv <= 3'h0;
			mclk <= 1'b0;
		end else begin
			mdiv <= (mdiv == 3'h4) ? 3'h0 : mdiv + 3'h1;
			if (mdiv == 3'h4) begin
				mclk <= ~mclk;
			end
		end
		if (!din_oe_n_i) begin
			last <= din_i;
		end else if (hdrv) begin
			last <= hdin;
		end
	end

	// Pulses held low/high for 4 cycles, 100 ns
	always @(posedge clock_i) begin
		if (cnv_left > 0) cnv_left <= cnv_left - 1;
		if (cnv_left == 1) cnv_n <= 1'b1;
		if (cal_left > 0) cal_left <= cal_left - 1;
		if (cal_left == 1) cal <= 1'b0;
	end

	// Released two-way pin shows the inverse of its last level
	assign pins_o = '{mclk: mclk, cnv_n: cnv_n, cal: cal, fsync: fsync, sclk: sclk,
		din: !din_oe_n_i ? din_i : (hdrv ? hdin : ~last)};

	task automatic start_conv();
		cnv_n <= 1'b0;
		cnv_left <= acs_pkg::CNV_LOW_MIN_CYC;
	endtask : start_conv

	task automatic req_cal();
		cal <= 1'b1;
		cal_left <= 4;
	endtask : req_cal

	// Serial clock runs only inside the frame, 200 ns period
	task automatic frame(input logic bidir, input logic [15:0] wr, output logic [15:0] rd, output logic rel);
		int n;
		n = bidir ? 32 : 16;
		rd = 16'h0000;
		fsync <= 1'b0;
		hdrv <= 1'b1;
		repeat (6) @(posedge clock_i);
		for (int i = 0; i < n; i++) begin
			hdin <= wr[15 - (i % 16)];
			repeat (4) @(posedge clock_i);
			sclk <= 1'b1;
			repeat (4) @(posedge clock_i);
			// Sample just before the fall: a new bit takes four cycles to reach the pin
			if (!bidir) rd = {rd[14:0], (!dout_oe_n_i ? dout_i : 1'bz)};
			if (bidir && i >= 16) rd = {rd[14:0], (!din_oe_n_i ? din_i : 1'bz)};
			sclk <= 1'b0;
			if (bidir && i == 15) hdrv <= 1'b0;
		end
		repeat (2) @(posedge clock_i);
		rel = din_oe_n_i;
		fsync <= 1'b1;
		hdrv <= 1'b0;
		repeat (6) @(posedge clock_i);
	endtask : frame
endmodule : acs_host_model

// ### dv/tb.sv
// Self-checking bench for the converter sequencer and serial port
`timescale 1ns/1ps
module tb;
	logic clock_i;
	logic nrst_i;
	acs_pkg::acs_pins_t pins_i;
	acs_pkg::acs_cal_t cal_mode_i;
	logic bidir_mode_i;
	logic [11:0] conv_result_i;
	logic busy_o;
	logic conv_done_o;
	logic dout_o;
	logic dout_oe_n_o;
	logic din_o;
	logic din_oe_n_o;
	logic [15:0] rx_word_o;
	logic rx_valid_o;
	int error_cnt = 0;
	int checks_done = 0;

	//----------------------------------------------------------------
	// Design and host
	//----------------------------------------------------------------
	// Short calibration counts keep the run brief
	acs_conv_serial #(.CAL_FULL_CYC_P(17'h00028), .CAL_DACFS_CYC_P(17'h0001E), .CAL_OFFS_CYC_P(17'h00014)) uut (
		.clock_i(clock_i), .nrst_i(nrst_i), .pins_i(pins_i), .cal_mode_i(cal_mode_i),
		.bidir_mode_i(bidir_mode_i), .conv_result_i(conv_result_i), .busy_o(busy_o),
		.conv_done_o(conv_done_o), .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o), .din_o(din_o),
		.din_oe_n_o(din_oe_n_o), .rx_word_o(rx_word_o), .rx_valid_o(rx_valid_o));
	acs_host_model h (.clock_i(clock_i), .nrst_i(nrst_i), .dout_i(dout_o), .dout_oe_n_i(dout_oe_n_o),
		.din_i(din_o), .din_oe_n_i(din_oe_n_o), .pins_o(pins_i));

	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end

	//----------------------------------------------------------------
	// Compare tasks
	//----------------------------------------------------------------
	task automatic chk_bit(input logic got, input logic exp, input string what);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected t=%0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask : chk_bit

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk_word

	task automatic chk_span(input int got, input int lo, input int hi, input string what);
		checks_done++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("unexpected t=%0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
		end
	endtask : chk_span

	//----------------------------------------------------------------
	// Scenarios
	//----------------------------------------------------------------
	// Master clock period is 10 system cycles
	task automatic t_seq(input logic is_cal, input acs_pkg::acs_cal_t m, input int mclks);
		int n;
		int d;
		n = 0;
		d = 0;
		cal_mode_i <= m;
		@(posedge clock_i);
		if (!is_cal) begin
			h.start_conv();
		end else begin
			h.req_cal();
			if (m == acs_pkg::CAL_DACFS || m == acs_pkg::CAL_OFFS) begin
				repeat (12) @(posedge clock_i);
				chk_bit(busy_o, 1'b0, "armed busy");
				h.start_conv();
			end
		end
		while (busy_o !== 1'b1 && n < 40) begin
			@(posedge clock_i);
			n++;
		end
		chk_span(n, 1, is_cal ? 26 : 6, "busy rise");
		while (busy_o === 1'b1 && d < 2000) begin
			@(posedge clock_i);
			d++;
			if (d == 30) h.start_conv();
		end
		chk_span(d, (mclks - 1) * 10 + 1, mclks * 10, "busy span");
		chk_bit(conv_done_o, 1'b1, "done pulse");
		@(posedge clock_i);
		chk_bit(conv_done_o, 1'b0, "done end");
		repeat (20) @(posedge clock_i);
		chk_bit(busy_o, 1'b0, "no restart");
		$display("test seq cal=%0b mode=%0d done", is_cal, m);
	endtask : t_seq

	task automatic t_frame(input logic bidir, input logic [15:0] wr, input logic [15:0] exp);
		logic [15:0] rd;
		logic rel;
		bidir_mode_i <= bidir;
		@(posedge clock_i);
		chk_bit(dout_oe_n_o, 1'b1, "dout idle");
		h.frame(bidir, wr, rd, rel);
		chk_word(rd, exp, "tx word");
		chk_word(rx_word_o, wr, "rx word");
		chk_bit(rel, 1'b1, "pin released");
		chk_bit(dout_oe_n_o, 1'b1, "dout released");
		$display("test frame bidir=%0b done", bidir);
	endtask : t_frame

	// Frame run while a conversion is busy; it still carries the previous result
	task automatic t_overlap(input logic [15:0] wr, input logic [15:0] exp);
		int d;
		d = 0;
		h.start_conv();
		t_frame(1'b0, wr, exp);
		chk_bit(busy_o, 1'b1, "busy during frame");
		while (busy_o === 1'b1 && d < 400) begin
			@(posedge clock_i);
			d++;
		end
		chk_bit(conv_done_o, 1'b1, "overlap done");
		repeat (20) @(posedge clock_i);
		$display("test overlap done");
	endtask : t_overlap

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (20000) @(posedge clock_i);
		error_cnt++;
		complete_run();
	end

	initial begin
		nrst_i = 1'b0;
		cal_mode_i = acs_pkg::CAL_FULL;
		bidir_mode_i = 1'b0;
		conv_result_i = 12'hB6D;
		repeat (16) @(posedge clock_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		t_seq(1'b0, acs_pkg::CAL_FULL, 18);
		t_frame(1'b0, 16'hC3A5, 16'h0B6D);
		t_frame(1'b1, 16'h5A3C, 16'h0B6D);
		t_seq(1'b1, acs_pkg::CAL_FULL, 40);
		t_seq(1'b1, acs_pkg::CAL_DACFS, 30);
		t_seq(1'b1, acs_pkg::CAL_OFFS, 20);
		t_seq(1'b1, acs_pkg::acs_cal_t'(2'h3), 40);
		t_frame(1'b0, 16'h8001, 16'h0B6D);
		conv_result_i <= 12'h4A9;
		t_seq(1'b0, acs_pkg::CAL_FULL, 18);
		t_frame(1'b1, 16'h7FFE, 16'h04A9);
		conv_result_i <= 12'h3C6;
		t_overlap(16'h1234, 16'h04A9);
		t_frame(1'b0, 16'hE817, 16'h03C6);
		complete_run();
	end
endmodule : tb

// ### verilog/acs_conv_serial.sv
// Converter conversion/calibration sequencer and serial port edge logic
`timescale 1ns/1ps
module acs_conv_serial #(
	parameter logic [16:0] CAL_FULL_CYC_P = acs_pkg::CAL_FULL_CYC,
	parameter logic [16:0] CAL_DACFS_CYC_P = acs_pkg::CAL_DACFS_CYC,
	parameter logic [16:0] CAL_OFFS_CYC_P = acs_pkg::CAL_OFFS_CYC
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Host pins, asynchronous to clock_i
	input wire acs_pkg::acs_pins_t pins_i,
	// Static configuration
	input wire acs_pkg::acs_cal_t cal_mode_i,
	input wire logic bidir_mode_i,
	// Converter core
	input wire logic [11:0] conv_result_i,
	output logic busy_o,
	output logic conv_done_o,
	// Serial pins
	output logic dout_o,
	output logic dout_oe_n_o,
	output logic din_o,
	output logic din_oe_n_o,
	// Received control word
	output logic [15:0] rx_word_o,
	output logic rx_valid_o
);

	//----------------------------------------------------------------
	// Decoding
	//----------------------------------------------------------------
	function automatic logic [16:0] cal_len(input acs_pkg::acs_cal_t m);
		case (m)
			acs_pkg::CAL_DACFS: cal_len = CAL_DACFS_CYC_P;
			acs_pkg::CAL_OFFS: cal_len = CAL_OFFS_CYC_P;
			default: cal_len = CAL_FULL_CYC_P;
		endcase
	endfunction : cal_len

	// Illegal mode codes behave as a full self-calibration
	function automatic logic is_self_cal(input acs_pkg::acs_cal_t m);
		is_self_cal = (m != acs_pkg::CAL_DACFS) && (m != acs_pkg::CAL_OFFS);
	endfunction : is_self_cal

	acs_pkg::acs_st_t st_r;
	acs_pkg::acs_st_t st_nxt;
	acs_pkg::acs_pins_t filt_nxt;
	acs_pkg::acs_pins_t rise;
	acs_pkg::acs_pins_t fall;

	//----------------------------------------------------------------
	// Pin filtering
	//----------------------------------------------------------------
	// A level is taken only once the second and third stages agree
	assign filt_nxt = acs_pkg::acs_pins_t'((~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.filt));
	assign rise = acs_pkg::acs_pins_t'(filt_nxt & ~st_r.filt);
	assign fall = acs_pkg::acs_pins_t'(~filt_nxt & st_r.filt);

	//----------------------------------------------------------------
	// Next state
	//----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pins_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.filt = filt_nxt;
		st_nxt.done = 1'h0;
		st_nxt.rx_valid = 1'h0;

		unique case (st_r.seq)
			acs_pkg::SEQ_IDLE: begin
				if (fall.cnv_n) begin
					st_nxt.seq = acs_pkg::SEQ_CONV;
					st_nxt.busy = 1'h1;
					st_nxt.cnt = acs_pkg::CONV_CYC;
				end else if (rise.cal) begin
					st_nxt.mode = cal_mode_i;
					if (is_self_cal(cal_mode_i)) begin
						st_nxt.seq = acs_pkg::SEQ_CAL;
						st_nxt.busy = 1'h1;
						st_nxt.cnt = cal_len(cal_mode_i);
					end else begin
						// System calibrations wait for the host to start the step
						st_nxt.seq = acs_pkg::SEQ_CALW;
					end
				end
			end
			acs_pkg::SEQ_CALW: begin
				if (fall.cnv_n) begin
					st_nxt.seq = acs_pkg::SEQ_CAL;
					st_nxt.busy = 1'h1;
					st_nxt.cnt = cal_len(st_r.mode);
				end
			end
			acs_pkg::SEQ_CONV, acs_pkg::SEQ_CAL: begin
				// Convert start edges are not looked at here
				if (rise.mclk) begin
					st_nxt.cnt = st_r.cnt - 17'h00001;
					if (st_r.cnt == 17'h00001) begin
						st_nxt.seq = acs_pkg::SEQ_IDLE;
						st_nxt.busy = 1'h0;
						st_nxt.done = 1'h1;
						if (st_r.seq == acs_pkg::SEQ_CONV) begin
							st_nxt.result = conv_result_i;
						end
					end
				end
			end
		endcase

		if (fall.fsync) begin
			st_nxt.frame = 1'h1;
			st_nxt.bits = 5'h00;
			st_nxt.armed = 1'h0;
			st_nxt.fbidir = bidir_mode_i;
			st_nxt.dout_en = ~bidir_mode_i;
			st_nxt.din_drv = 1'h0;
			st_nxt.tx = {acs_pkg::TX_PAD, st_r.result};
		end else if (rise.fsync) begin
			st_nxt.frame = 1'h0;
			st_nxt.dout_en = 1'h0;
			st_nxt.din_drv = 1'h0;
		end else if (st_r.frame) begin
			if (rise.sclk) begin
				st_nxt.bits = st_r.bits + 5'h01;
				st_nxt.armed = 1'h1;
				if (!st_r.din_drv && st_r.bits <= acs_pkg::RX_LAST_BIT) begin
					st_nxt.rx = {st_r.rx[14:0], filt_nxt.din};
				end
				if (!st_r.din_drv && st_r.bits == acs_pkg::RX_LAST_BIT) begin
					st_nxt.rx_word = {st_r.rx[14:0], filt_nxt.din};
					st_nxt.rx_valid = 1'h1;
					if (st_r.fbidir) begin
						// Turn the pin round and present the MSB at once
						st_nxt.din_drv = 1'h1;
						st_nxt.armed = 1'h0;
						st_nxt.tx = {acs_pkg::TX_PAD, st_r.result};
					end
				end
				if (st_r.din_drv && st_r.bits == acs_pkg::TX_LAST_BIT) begin
					st_nxt.din_drv = 1'h0;
				end
			end else if (fall.sclk && st_r.armed) begin
				// Shift only after a rising edge, so a leading falling edge keeps the MSB
				st_nxt.tx = {st_r.tx[14:0], 1'h0};
				st_nxt.armed = 1'h0;
			end
		end
	end

	//----------------------------------------------------------------
	// State register
	//----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= acs_pkg::ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign busy_o = st_r.busy;
	assign conv_done_o = st_r.done;
	assign dout_o = st_r.tx[15];
	assign din_o = st_r.tx[15];
	assign dout_oe_n_o = ~st_r.dout_en;
	assign din_oe_n_o = ~st_r.din_drv;
	assign rx_word_o = st_r.rx_word;
	assign rx_valid_o = st_r.rx_valid;

	//----------------------------------------------------------------
	// Checks
	//----------------------------------------------------------------
	localparam int BUSY_MAX = acs_pkg::BUSY_RISE_MAX_CYC;

	// Independent count of master clock rises while busy
	logic [16:0] h_mcnt_r;
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			h_mcnt_r <= 17'h00000;
		end else if (!st_r.busy) begin
			h_mcnt_r <= 17'h00000;
		end else if (rise.mclk) begin
			h_mcnt_r <= h_mcnt_r + 17'h00001;
		end
	end

	property p_conv_len;
		@(posedge clock_i) disable iff (!nrst_i)
		$fell(busy_o) && $past(st_r.seq) == acs_pkg::SEQ_CONV |-> h_mcnt_r == acs_pkg::CONV_CYC;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

	property p_cal_full;
		@(posedge clock_i) disable iff (!nrst_i)
		$fell(busy_o) && $past(st_r.seq) == acs_pkg::SEQ_CAL && is_self_cal(st_r.mode)
			|-> h_mcnt_r == CAL_FULL_CYC_P;
	endproperty
	a_cal_full: assert property (p_cal_full) else $error("self calibration length wrong");

	property p_cal_dacfs;
		@(posedge clock_i) disable iff (!nrst_i)
		$fell(busy_o) && $past(st_r.seq) == acs_pkg::SEQ_CAL && st_r.mode == acs_pkg::CAL_DACFS
			|-> h_mcnt_r == CAL_DACFS_CYC_P;
	endproperty
	a_cal_dacfs: assert property (p_cal_dacfs) else $error("full-scale calibration length wrong");

	property p_cal_offs;
		@(posedge clock_i) disable iff (!nrst_i)
		$fell(busy_o) && $past(st_r.seq) == acs_pkg::SEQ_CAL && st_r.mode == acs_pkg::CAL_OFFS
			|-> h_mcnt_r == CAL_OFFS_CYC_P;
	endproperty
	a_cal_offs: assert property (p_cal_offs) else $error("offset calibration length wrong");

	property p_cal_busy;
		@(posedge clock_i) disable iff (!nrst_i)
		(st_r.seq == acs_pkg::SEQ_IDLE && rise.cal && !fall.cnv_n && is_self_cal(cal_mode_i))
			|| (st_r.seq == acs_pkg::SEQ_CALW && fall.cnv_n) |-> ##[1:BUSY_MAX] busy_o;
	endproperty
	a_cal_busy: assert property (p_cal_busy) else $error("busy late after calibration start");

	property p_conv_start;
		@(posedge clock_i) disable iff (!nrst_i)
		st_r.seq == acs_pkg::SEQ_IDLE && fall.cnv_n
			|=> busy_o && st_r.seq == acs_pkg::SEQ_CONV && st_r.cnt == acs_pkg::CONV_CYC;
	endproperty
	a_conv_start: assert property (p_conv_start) else $error("conversion did not start");

	property p_dout_hiz;
		@(posedge clock_i) disable iff (!nrst_i)
		$fell(dout_oe_n_o) |-> $past(fall.fsync) && !st_r.filt.fsync;
	endproperty
	a_dout_hiz: assert property (p_dout_hiz) else $error("serial output driven outside frame");

	property p_release;
		@(posedge clock_i) disable iff (!nrst_i)
		rise.fsync |=> dout_oe_n_o && din_oe_n_o;
	endproperty
	a_release: assert property (p_release) else $error("line not released after frame sync");

	property p_sample;
		@(posedge clock_i) disable iff (!nrst_i)
		st_r.frame && rise.sclk && !fall.fsync && !rise.fsync && !st_r.din_drv && st_r.bits <= acs_pkg::RX_LAST_BIT
			|=> st_r.rx[0] == $past(filt_nxt.din);
	endproperty
	a_sample: assert property (p_sample) else $error("input bit not captured");

	property p_dout_upd;
		@(posedge clock_i) disable iff (!nrst_i)
		$changed(dout_o) && $past(st_r.frame) && !$past(fall.fsync) && !st_r.fbidir |-> $past(fall.sclk);
	endproperty
	a_dout_upd: assert property (p_dout_upd) else $error("output bit changed off falling clock");

	property p_din_out;
		@(posedge clock_i) disable iff (!nrst_i)
		$fell(din_oe_n_o) |-> $past(rise.sclk) && $past(st_r.bits) == acs_pkg::RX_LAST_BIT;
	endproperty
	a_din_out: assert property (p_din_out) else $error("pin turned to output off rising clock");

	property p_din_in;
		@(posedge clock_i) disable iff (!nrst_i)
		$rose(din_oe_n_o) |-> $past(rise.sclk) || $past(rise.fsync);
	endproperty
	a_din_in: assert property (p_din_in) else $error("pin released off rising clock");

	property p_done;
		@(posedge clock_i) disable iff (!nrst_i)
		$fell(busy_o) |-> conv_done_o ##1 !conv_done_o;
	endproperty
	a_done: assert property (p_done) else $error("end of interval not marked");

	property p_ignore;
		@(posedge clock_i) disable iff (!nrst_i)
		st_r.busy && fall.cnv_n && !rise.mclk |=> $stable(st_r.cnt) && $stable(st_r.seq);
	endproperty
	a_ignore: assert property (p_ignore) else $error("convert start acted on while busy");

	property p_conv_busy;
		@(posedge clock_i) disable iff (!nrst_i)
		st_r.seq == acs_pkg::SEQ_CONV |-> busy_o;
	endproperty
	a_conv_busy: assert property (p_conv_busy) else $error("busy low during conversion");

	property p_idle_free;
		@(posedge clock_i) disable iff (!nrst_i)
		st_r.seq == acs_pkg::SEQ_IDLE || st_r.seq == acs_pkg::SEQ_CALW |-> !busy_o;
	endproperty
	a_idle_free: assert property (p_idle_free) else $error("busy high with no interval running");

	property p_idle_hiz;
		@(posedge clock_i) disable iff (!nrst_i)
		!st_r.frame |-> dout_oe_n_o && din_oe_n_o;
	endproperty
	a_idle_hiz: assert property (p_idle_hiz) else $error("serial pin driven outside frame");

	c_conv: cover property (@(posedge clock_i) disable iff (!nrst_i)
		$fell(busy_o) && $past(st_r.seq) == acs_pkg::SEQ_CONV);
	c_cal: cover property (@(posedge clock_i) disable iff (!nrst_i)
		$fell(busy_o) && $past(st_r.seq) == acs_pkg::SEQ_CAL);
	c_rx: cover property (@(posedge clock_i) disable iff (!nrst_i) rx_valid_o);
	c_armed: cover property (@(posedge clock_i) disable iff (!nrst_i)
		st_r.seq == acs_pkg::SEQ_CALW && fall.cnv_n);
	c_turn: cover property (@(posedge clock_i) disable iff (!nrst_i) $fell(din_oe_n_o) ##[1:1000] $rose(din_oe_n_o));

endmodule : acs_conv_serial

// ### verilog/acs_pkg.sv
// Constants, types and state layout for converter sequencing and serial port
// Summary of operation
// - Conversion lasts exactly 18 master clocks, busy throughout
// - Full self-calibration lasts 125013 master clocks
// - DAC plus full-scale calibration lasts 111114 clocks
// - System offset calibration lasts 13899 master clocks
// - Calibration start raises busy within 2.5 clocks
// - Falling convert start begins conversion, raises busy
// - Serial output undriven until frame sync falls
// - Frame sync rising releases serial output line
// - Incoming serial data sampled on rising clock
// - Outgoing bit updated after falling serial clock
// - Bidirectional pin becomes output after rising clock
// - Pin returns input after rising clock; host waits
package acs_pkg;

	//----------------------------------------------------------------
	// Timing
	//----------------------------------------------------------------
	localparam int CLK_NS = 25;
	localparam int MCLK_TYP_NS = 250;
	localparam logic [16:0] CONV_CYC = 17'h00012;
	localparam logic [16:0] CAL_FULL_CYC = 17'h1E855;
	localparam logic [16:0] CAL_DACFS_CYC = 17'h1B20A;
	localparam logic [16:0] CAL_OFFS_CYC = 17'h0364B;
	// Typical figures at a 4 MHz master clock, for reference only
	localparam real CAL_FULL_MS = 31.25;
	localparam real CAL_DACFS_MS = 27.78;
	localparam real CAL_OFFS_MS = 3.47;
	localparam real BUSY_RISE_MCLK = 2.5;
	localparam int BUSY_RISE_MAX_CYC = int'($floor(BUSY_RISE_MCLK * MCLK_TYP_NS / CLK_NS));
	localparam real CNV_LOW_MIN_NS = 100.0;
	localparam int CNV_LOW_MIN_CYC = int'($ceil(CNV_LOW_MIN_NS / CLK_NS));
	localparam real ACQ_MIN_NS = 400.0;
	localparam int ACQ_MIN_CYC = int'($ceil(ACQ_MIN_NS / CLK_NS));

	//----------------------------------------------------------------
	// Serial framing
	//----------------------------------------------------------------
	localparam logic [4:0] RX_LAST_BIT = 5'h0F;
	localparam logic [4:0] TX_LAST_BIT = 5'h1F;
	localparam logic [3:0] TX_PAD = 4'h0;

	//----------------------------------------------------------------
	// Types
	//----------------------------------------------------------------
	typedef struct packed {
		logic mclk;
		logic cnv_n;
		logic cal;
		logic fsync;
		logic sclk;
		logic din;
	} acs_pins_t;

	localparam acs_pins_t PINS_IDLE = '{mclk: 1'h0, cnv_n: 1'h1, cal: 1'h0, fsync: 1'h1, sclk: 1'h0, din: 1'h0};

	typedef enum logic [1:0] {CAL_FULL, CAL_DACFS, CAL_OFFS} acs_cal_t;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONV, SEQ_CALW, SEQ_CAL} acs_seq_t;

	typedef struct packed {
		acs_pins_t s1;
		acs_pins_t s2;
		acs_pins_t s3;
		acs_pins_t filt;
		acs_seq_t seq;
		acs_cal_t mode;
		logic [16:0] cnt;
		logic busy;
		logic done;
		logic [11:0] result;
		logic frame;
		logic fbidir;
		logic dout_en;
		logic din_drv;
		logic armed;
		logic [4:0] bits;
		logic [15:0] tx;
		logic [15:0] rx;
		logic [15:0] rx_word;
		logic rx_valid;
	} acs_st_t;

	localparam acs_st_t ST_RST = '{s1: PINS_IDLE, s2: PINS_IDLE, s3: PINS_IDLE, filt: PINS_IDLE,
		seq: SEQ_IDLE, mode: CAL_FULL, default: '0};

endpackage : acs_pkg
